// [logic/krltr_field.sv]
// Purpose: one remote request field held between received frames
// Assumes: load comes from logic on the same clock
// Notes: holds its value while load is low
`timescale 1ns/1ps
module krltr_field #(
    parameter int W = 2,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] val_next;

    always_comb begin
        val_next = load ? d : q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= RST_VAL;
        end else begin
            q <= val_next;
        end
    end
endmodule : krltr_field

// [logic/krltr_pkg.sv]
// What this block does
// - control register resets to 0x0002 in management device 0x01: enabled, no restart.
// - enable bit 1 set means the start-up training protocol runs; resets to one.
// - enable bit cleared means the start-up training protocol does not run.
// - writing one to control bit 0 restarts training only if the same write sets enable bit 1 to one; bit self-clears, reads zero.
// - control bits 15 to 2 always read zero.
// - status bit 3 reads one once a training failure was detected.
// - status bit 2 reads one while the protocol runs, zero once complete.
// - status bit 1 reads one while training frame lock is held.
// - status bit 0 reads one when the local receiver is trained and ready.
// - status bits 15 to 4 are reserved and read zero; status resets to 0x0000.
// - remote request bit 13 reads one when the partner requested preset.
// - remote request bit 12 reads one when the partner requested initialize.
// - each tap request is a two-bit code: 01 inc, 10 dec, 00 hold.
// - precursor field and whole remote request register reset to hold, 0x0000.
//
// Purpose: constants of the link training register bank
// Assumes: 16-bit management registers, one clock
// Notes: offsets are the management register addresses
package krltr_pkg;
    localparam logic [4:0] KRLTR_DEV_ADDR = 5'h01;
    localparam logic [15:0] KRLTR_CTRL_OFS = 16'h0096;
    localparam logic [15:0] KRLTR_STAT_OFS = 16'h0097;
    localparam logic [15:0] KRLTR_LPC_OFS = 16'h0098;

    localparam logic [15:0] KRLTR_CTRL_RST = 16'h0002;
    localparam logic [15:0] KRLTR_STAT_RST = 16'h0000;
    localparam logic [15:0] KRLTR_LPC_RST = 16'h0000;

    localparam int KRLTR_CTRL_EN_BIT = 1;
    localparam int KRLTR_CTRL_RESTART_BIT = 0;

    localparam int KRLTR_ST_FAIL_BIT = 3;
    localparam int KRLTR_ST_PROG_BIT = 2;
    localparam int KRLTR_ST_LOCK_BIT = 1;
    localparam int KRLTR_ST_RXRDY_BIT = 0;

    localparam int KRLTR_LP_PRESET_BIT = 13;
    localparam int KRLTR_LP_INIT_BIT = 12;
    localparam int KRLTR_LP_SWG_LSB = 8;
    localparam int KRLTR_LP_PS2_LSB = 6;
    localparam int KRLTR_LP_P1_LSB = 4;
    localparam int KRLTR_LP_K0_LSB = 2;
    localparam int KRLTR_LP_M1_LSB = 0;

    typedef enum logic [1:0] {
        KRLTR_REQ_HOLD = 2'h0,
        KRLTR_REQ_INC = 2'h1,
        KRLTR_REQ_DEC = 2'h2,
        KRLTR_REQ_RSVD = 2'h3
    } krltr_req_t;

    typedef enum logic [1:0] {
        KRLTR_IDLE = 2'h0,
        KRLTR_RUN = 2'h1,
        KRLTR_DONE = 2'h3,
        KRLTR_FAIL = 2'h2
    } krltr_state_t;
endpackage : krltr_pkg

// [logic/krltr_regs.sv]
// Purpose: control and status registers of the link training start-up protocol
// Assumes: training engine inputs share clk; management port is a simple strobe port
// Notes: reads answer one cycle after the read strobe
`timescale 1ns/1ps
module krltr_regs import krltr_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] mgmtDevAddr,
    input wire logic [15:0] mgmtRegAddr,
    input wire logic mgmtWrEn,
    input wire logic mgmtRdEn,
    input wire logic [15:0] mgmtWrData,
    output logic [15:0] mgmtRdData,
    output logic mgmtRdValid,
    output logic startupProtocolOn,
    output logic retrainRequest,
    output logic protocolInProgress,
    input wire logic trainFrameLocked,
    input wire logic localRxTrained,
    input wire logic trainDone,
    input wire logic trainFailEvent,
    input wire logic rxFrameValid,
    input wire logic remotePresetIn,
    input wire logic remoteInitIn,
    input wire logic [1:0] remoteSwingIn,
    input wire logic [1:0] remotePost2In,
    input wire logic [1:0] remotePostcursorIn,
    input wire logic [1:0] remoteMaincursorIn,
    input wire logic [1:0] remotePrecursorIn
);
    // address decode
    logic devHit;
    logic ctrlWr;
    logic ctrlRd;
    logic statRd;
    logic lpcRd;

    assign devHit = (mgmtDevAddr == KRLTR_DEV_ADDR);
    assign ctrlWr = mgmtWrEn && devHit && (mgmtRegAddr == KRLTR_CTRL_OFS);
    assign ctrlRd = mgmtRdEn && devHit && (mgmtRegAddr == KRLTR_CTRL_OFS);
    assign statRd = mgmtRdEn && devHit && (mgmtRegAddr == KRLTR_STAT_OFS);
    assign lpcRd = mgmtRdEn && devHit && (mgmtRegAddr == KRLTR_LPC_OFS);

    // control register
    logic enable_reg;
    logic enable_next;
    logic restartReq;

    always_comb begin
        enable_next = enable_reg;
        if (ctrlWr) begin
            enable_next = mgmtWrData[KRLTR_CTRL_EN_BIT];
        end
    end

    // restart is honoured only if the protocol is (or becomes) enabled
    assign restartReq = ctrlWr && mgmtWrData[KRLTR_CTRL_RESTART_BIT] && enable_next;

    always_ff @(posedge clk) begin
        if (srst) begin
            enable_reg <= KRLTR_CTRL_RST[KRLTR_CTRL_EN_BIT];
        end else begin
            enable_reg <= enable_next;
        end
    end

    // protocol run state
    krltr_state_t state_reg;
    krltr_state_t state_next;
    logic startRun;
    logic failed_reg;
    logic failed_next;
    logic prog_next;
    logic lock_reg;
    logic lock_next;
    logic rxRdy_reg;
    logic rxRdy_next;
    logic retrain_next;

    always_comb begin
        state_next = state_reg;
        startRun = 1'b0;
        case (state_reg)
            KRLTR_IDLE: begin
                if (enable_reg || restartReq) begin
                    state_next = KRLTR_RUN;
                    startRun = 1'b1;
                end
            end
            KRLTR_RUN: begin
                if (!enable_reg) begin
                    state_next = KRLTR_IDLE;
                end else if (trainFailEvent) begin
                    // a failure seen with a restart in the same cycle is kept
                    state_next = KRLTR_FAIL;
                end else if (restartReq) begin
                    startRun = 1'b1;
                end else if (trainDone) begin
                    state_next = KRLTR_DONE;
                end
            end
            KRLTR_DONE, KRLTR_FAIL: begin
                if (!enable_reg) begin
                    state_next = KRLTR_IDLE;
                end else if (restartReq) begin
                    state_next = KRLTR_RUN;
                    startRun = 1'b1;
                end
            end
            default: begin
                state_next = KRLTR_IDLE;
            end
        endcase
    end

    always_comb begin
        failed_next = (state_next == KRLTR_FAIL);
        prog_next = (state_next == KRLTR_RUN);
        lock_next = trainFrameLocked;
        // ready drops on restart; the engine then reports it afresh
        rxRdy_next = localRxTrained && !startRun;
        retrain_next = startRun;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= KRLTR_IDLE;
            failed_reg <= KRLTR_STAT_RST[KRLTR_ST_FAIL_BIT];
            protocolInProgress <= KRLTR_STAT_RST[KRLTR_ST_PROG_BIT];
            lock_reg <= KRLTR_STAT_RST[KRLTR_ST_LOCK_BIT];
            rxRdy_reg <= KRLTR_STAT_RST[KRLTR_ST_RXRDY_BIT];
            retrainRequest <= 1'b0;
            startupProtocolOn <= KRLTR_CTRL_RST[KRLTR_CTRL_EN_BIT];
        end else begin
            state_reg <= state_next;
            failed_reg <= failed_next;
            protocolInProgress <= prog_next;
            lock_reg <= lock_next;
            rxRdy_reg <= rxRdy_next;
            retrainRequest <= retrain_next;
            startupProtocolOn <= enable_next;
        end
    end

    // remote coefficient requests, loaded only from locked frames
    logic lpLoad;
    logic presetQ;
    logic initQ;
    logic [1:0] swingQ;
    logic [1:0] post2Q;
    logic [1:0] postQ;
    logic [1:0] mainQ;
    logic [1:0] preQ;

    assign lpLoad = rxFrameValid && trainFrameLocked;

    krltr_field #(.W(1), .RST_VAL(KRLTR_LPC_RST[KRLTR_LP_PRESET_BIT])) u_preset (
        .clk(clk), .srst(srst), .load(lpLoad), .d(remotePresetIn), .q(presetQ));
    krltr_field #(.W(1), .RST_VAL(KRLTR_LPC_RST[KRLTR_LP_INIT_BIT])) u_init (
        .clk(clk), .srst(srst), .load(lpLoad), .d(remoteInitIn), .q(initQ));
    krltr_field #(.W(2), .RST_VAL(KRLTR_REQ_HOLD)) u_swing (
        .clk(clk), .srst(srst), .load(lpLoad), .d(remoteSwingIn), .q(swingQ));
    krltr_field #(.W(2), .RST_VAL(KRLTR_REQ_HOLD)) u_post2 (
        .clk(clk), .srst(srst), .load(lpLoad), .d(remotePost2In), .q(post2Q));
    krltr_field #(.W(2), .RST_VAL(KRLTR_REQ_HOLD)) u_post (
        .clk(clk), .srst(srst), .load(lpLoad), .d(remotePostcursorIn), .q(postQ));
    krltr_field #(.W(2), .RST_VAL(KRLTR_REQ_HOLD)) u_main (
        .clk(clk), .srst(srst), .load(lpLoad), .d(remoteMaincursorIn), .q(mainQ));
    krltr_field #(.W(2), .RST_VAL(KRLTR_REQ_HOLD)) u_pre (
        .clk(clk), .srst(srst), .load(lpLoad), .d(remotePrecursorIn), .q(preQ));

    // read words; reserved bits stay zero
    logic [15:0] ctrlWord;
    logic [15:0] statWord;
    logic [15:0] lpcWord;

    always_comb begin
        ctrlWord = 16'h0000;
        ctrlWord[KRLTR_CTRL_EN_BIT] = enable_reg;
        statWord = 16'h0000;
        statWord[KRLTR_ST_FAIL_BIT] = failed_reg;
        statWord[KRLTR_ST_PROG_BIT] = protocolInProgress;
        statWord[KRLTR_ST_LOCK_BIT] = lock_reg;
        statWord[KRLTR_ST_RXRDY_BIT] = rxRdy_reg;
        lpcWord = 16'h0000;
        lpcWord[KRLTR_LP_PRESET_BIT] = presetQ;
        lpcWord[KRLTR_LP_INIT_BIT] = initQ;
        lpcWord[KRLTR_LP_SWG_LSB +: 2] = swingQ;
        lpcWord[KRLTR_LP_PS2_LSB +: 2] = post2Q;
        lpcWord[KRLTR_LP_P1_LSB +: 2] = postQ;
        lpcWord[KRLTR_LP_K0_LSB +: 2] = mainQ;
        lpcWord[KRLTR_LP_M1_LSB +: 2] = preQ;
    end

    logic [15:0] rdData_next;
    logic rdValid_next;

    always_comb begin
        rdValid_next = mgmtRdEn;
        // unmapped addresses and other devices read as zero
        rdData_next = 16'h0000;
        if (ctrlRd) begin
            rdData_next = ctrlWord;
        end else if (statRd) begin
            rdData_next = statWord;
        end else if (lpcRd) begin
            rdData_next = lpcWord;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mgmtRdData <= 16'h0000;
            mgmtRdValid <= 1'b0;
        end else begin
            mgmtRdData <= rdData_next;
            mgmtRdValid <= rdValid_next;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_ctrl_reset;
        disable iff (1'b0) srst |=> enable_reg && state_reg == KRLTR_IDLE && !retrainRequest;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not at reset value");

    property p_run_when_on;
        enable_reg && state_reg == KRLTR_IDLE |=> retrainRequest && protocolInProgress;
    endproperty
    a_run_when_on: assert property (p_run_when_on) else $error("enabled protocol did not start");

    property p_no_run_off;
        !enable_reg && !ctrlWr |=> !protocolInProgress && !retrainRequest;
    endproperty
    a_no_run_off: assert property (p_no_run_off) else $error("protocol ran while disabled");

    property p_restart_pulse;
        restartReq && state_reg != KRLTR_RUN |=> retrainRequest ##1 !retrainRequest;
    endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart gave no single pulse");

    property p_ctrl_read;
        ctrlRd |=> mgmtRdValid && mgmtRdData[15:2] == 14'h0000 && !mgmtRdData[KRLTR_CTRL_RESTART_BIT];
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read reserved or restart set");

    property p_fail_seen;
        state_reg == KRLTR_RUN && enable_reg && trainFailEvent |=> failed_reg && !protocolInProgress;
    endproperty
    a_fail_seen: assert property (p_fail_seen) else $error("failure not shown");

    property p_done_clears;
        state_reg == KRLTR_RUN && enable_reg && trainDone && !trainFailEvent && !restartReq
            |=> !protocolInProgress && !failed_reg;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("progress stuck after done");

    property p_lock_read;
        // the lock bit holds its reset value in the first cycle after reset
        statRd && !$past(srst) |=> mgmtRdData[KRLTR_ST_LOCK_BIT] == $past(trainFrameLocked, 2);
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("frame lock bit wrong");

    property p_ready_drop;
        startRun |=> !rxRdy_reg;
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready kept across restart");

    property p_stat_read;
        statRd |=> mgmtRdData[15:4] == 12'h000;
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status reserved bits set");

    property p_lp_load;
        lpLoad |=> presetQ == $past(remotePresetIn) && initQ == $past(remoteInitIn)
            && swingQ == $past(remoteSwingIn) && preQ == $past(remotePrecursorIn);
    endproperty
    a_lp_load: assert property (p_lp_load) else $error("remote request not captured");

    property p_lp_reset;
        disable iff (1'b0) srst |=> lpcWord == KRLTR_LPC_RST;
    endproperty
    a_lp_reset: assert property (p_lp_reset) else $error("remote requests not cleared");

    property p_lp_hold;
        !lpLoad |=> $stable(lpcWord);
    endproperty
    a_lp_hold: assert property (p_lp_hold) else $error("remote requests changed without lock");

    property p_restart_fail;
        state_reg == KRLTR_FAIL && restartReq |=> !failed_reg && protocolInProgress;
    endproperty
    a_restart_fail: assert property (p_restart_fail) else $error("restart did not clear failure");

    c_done: cover property (protocolInProgress ##1 state_reg == KRLTR_DONE);
    c_fail: cover property (protocolInProgress ##1 failed_reg);
    c_retrain: cover property (state_reg == KRLTR_FAIL && restartReq);
    c_lp_read: cover property (lpLoad ##1 lpcRd);
endmodule : krltr_regs

// [verif/krltr_engine_model.sv]
// Purpose: training engine stand-in that ends each run not aborted by a disable with done or fail
// Assumes: a run starts on the retrain pulse
// Notes: failRun picks the outcome; the bench sets it only in the failure scenario
`timescale 1ns/1ps
module krltr_engine_model #(
    parameter int RUN_LEN = 12
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic retrainRequest,
    input wire logic protocolInProgress,
    input wire logic failRun,
    output logic trainDone,
    output logic trainFailEvent
);
    logic [7:0] cnt_reg;

    always_ff @(posedge clk) begin
        trainDone <= 1'b0;
        trainFailEvent <= 1'b0;
        if (srst) begin
            cnt_reg <= 8'h00;
        end else if (retrainRequest) begin
            cnt_reg <= 8'(RUN_LEN);
        end else if (!protocolInProgress) begin
            // a disable aborts the run, so no stale done pulse follows
            cnt_reg <= 8'h00;
        end else if (cnt_reg == 8'h01) begin
            cnt_reg <= 8'h00;
            trainDone <= !failRun;
            trainFailEvent <= failRun;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
endmodule : krltr_engine_model

// [verif/krltr_regs_tb.sv]
// Purpose: self-checking bench for the training register bank
// Assumes: engine pulses come from the engine model
// Notes: bench inputs move on the falling edge
`timescale 1ns/1ps
module krltr_regs_tb import krltr_pkg::*;;
    logic clk, srst, mgmtWrEn, mgmtRdEn, trainFrameLocked, localRxTrained, rxFrameValid;
    logic remotePresetIn, remoteInitIn, failRun, trainDone, trainFailEvent;
    logic mgmtRdValid, startupProtocolOn, retrainRequest, protocolInProgress;
    logic [4:0] mgmtDevAddr;
    logic [15:0] mgmtRegAddr, mgmtWrData, mgmtRdData, lastLpc;
    logic [1:0] remoteSwingIn, remotePost2In, remotePostcursorIn, remoteMaincursorIn, remotePrecursorIn;
    int errCount, samplesChecked, pulseCnt;

    krltr_regs dut (.clk, .srst, .mgmtDevAddr, .mgmtRegAddr, .mgmtWrEn, .mgmtRdEn, .mgmtWrData,
        .mgmtRdData, .mgmtRdValid, .startupProtocolOn, .retrainRequest, .protocolInProgress,
        .trainFrameLocked, .localRxTrained, .trainDone, .trainFailEvent, .rxFrameValid,
        .remotePresetIn, .remoteInitIn, .remoteSwingIn, .remotePost2In, .remotePostcursorIn,
        .remoteMaincursorIn, .remotePrecursorIn);
    krltr_engine_model #(.RUN_LEN(12)) eng (.clk, .srst, .retrainRequest, .protocolInProgress,
        .failRun, .trainDone, .trainFailEvent);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // the retrain pulse stands one cycle, so count it at every falling edge
    always @(negedge clk) if (retrainRequest === 1'b1) pulseCnt++;

    task close_out;
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        mgmtDevAddr = KRLTR_DEV_ADDR;
        mgmtRegAddr = a;
        mgmtWrData = d;
        mgmtWrEn = 1'b1;
        @(negedge clk);
        mgmtWrEn = 1'b0;
    endtask : wr

    task rd(input logic [4:0] dv, input logic [15:0] a, input logic [15:0] exp, input string nm);
        int i;
        @(negedge clk);
        mgmtDevAddr = dv;
        mgmtRegAddr = a;
        mgmtRdEn = 1'b1;
        @(negedge clk);
        mgmtRdEn = 1'b0;
        for (i = 0; i < 3 && mgmtRdValid !== 1'b1; i++) @(negedge clk);
        if (i == 3) begin
            chk("read valid", 16'h0001, 16'h0000);
            close_out();
        end
        // the answer must stand exactly one cycle after the strobe
        chk("read latency", 16'h0000, 16'(i));
        chk(nm, exp, mgmtRdData);
    endtask : rd

    task waitProg(input logic v);
        int i;
        for (i = 0; i < 200 && protocolInProgress !== v; i++) @(negedge clk);
        if (i == 200) begin
            chk("progress wait", {15'h0, v}, {15'h0, protocolInProgress});
            close_out();
        end
    endtask : waitProg

    task frame(input logic [11:0] v);
        @(negedge clk);
        {remotePresetIn, remoteInitIn, remoteSwingIn, remotePost2In} = v[11:6];
        {remotePostcursorIn, remoteMaincursorIn, remotePrecursorIn} = v[5:0];
        rxFrameValid = 1'b1;
        @(negedge clk);
        rxFrameValid = 1'b0;
    endtask : frame

    task sc_reset;
        rd(KRLTR_DEV_ADDR, KRLTR_CTRL_OFS, 16'h0002, "ctrl reset");
        rd(KRLTR_DEV_ADDR, KRLTR_LPC_OFS, 16'h0000, "lpc reset");
        rd(KRLTR_DEV_ADDR, KRLTR_STAT_OFS, 16'h0004, "status in run");
        chk("autostart", 16'h0001, 16'(pulseCnt));
    endtask : sc_reset

    task sc_done;
        waitProg(1'b0);
        rd(KRLTR_DEV_ADDR, KRLTR_STAT_OFS, 16'h0000, "status done");
        trainFrameLocked = 1'b1;
        localRxTrained = 1'b1;
        repeat (2) @(negedge clk);
        rd(KRLTR_DEV_ADDR, KRLTR_STAT_OFS, 16'h0003, "lock ready");
    endtask : sc_done

    task sc_frames;
        logic [1:0] k;
        logic [11:0] v;
        for (int c = 0; c < 4; c++) begin
            k = 2'(c);
            // rotated codes per field so a swapped field shows up, except swing with precursor, which both carry k
            v = {k[0], ~k[0], k, k + 2'h1, k + 2'h2, k + 2'h3, k};
            frame(v);
            lastLpc = {2'b00, v[11:10], 2'b00, v[9:0]};
            rd(KRLTR_DEV_ADDR, KRLTR_LPC_OFS, lastLpc, "lpc fields");
        end
        trainFrameLocked = 1'b0;
        frame(12'h5a5);
        rd(KRLTR_DEV_ADDR, KRLTR_LPC_OFS, lastLpc, "lpc held unlocked");
        trainFrameLocked = 1'b1;
    endtask : sc_frames

    task sc_ctrl;
        wr(KRLTR_CTRL_OFS, 16'hfffe);
        rd(KRLTR_DEV_ADDR, KRLTR_CTRL_OFS, 16'h0002, "ctrl reserved");
        wr(KRLTR_CTRL_OFS, 16'h0000);
        chk("enable out off", 16'h0000, {15'h0, startupProtocolOn});
        rd(KRLTR_DEV_ADDR, KRLTR_CTRL_OFS, 16'h0000, "ctrl disabled");
        pulseCnt = 0;
        wr(KRLTR_CTRL_OFS, 16'h0001);
        repeat (3) @(negedge clk);
        chk("restart when off", 16'h0000, 16'(pulseCnt));
        chk("progress when off", 16'h0000, {15'h0, protocolInProgress});
        rd(KRLTR_DEV_ADDR, KRLTR_CTRL_OFS, 16'h0000, "restart self clear");
        wr(KRLTR_CTRL_OFS, 16'h0002);
        chk("enable out on", 16'h0001, {15'h0, startupProtocolOn});
        repeat (2) @(negedge clk);
        chk("reenable run", 16'h0001, 16'(pulseCnt));
        waitProg(1'b0);
    endtask : sc_ctrl

    task sc_fail;
        localRxTrained = 1'b0;
        failRun = 1'b1;
        pulseCnt = 0;
        wr(KRLTR_CTRL_OFS, 16'h0003);
        @(negedge clk);
        chk("restart pulse", 16'h0001, 16'(pulseCnt));
        waitProg(1'b0);
        rd(KRLTR_DEV_ADDR, KRLTR_STAT_OFS, 16'h000a, "failed");
        failRun = 1'b0;
        wr(KRLTR_CTRL_OFS, 16'h0003);
        rd(KRLTR_DEV_ADDR, KRLTR_STAT_OFS, 16'h0006, "restart clears");
        rd(KRLTR_DEV_ADDR, KRLTR_CTRL_OFS, 16'h0002, "restart reads zero");
        waitProg(1'b0);
        rd(KRLTR_DEV_ADDR, KRLTR_STAT_OFS, 16'h0002, "run complete");
    endtask : sc_fail

    task sc_refuse;
        wr(KRLTR_STAT_OFS, 16'hffff);
        rd(KRLTR_DEV_ADDR, KRLTR_STAT_OFS, 16'h0002, "status read only");
        rd(5'h02, KRLTR_CTRL_OFS, 16'h0000, "other device");
        rd(KRLTR_DEV_ADDR, 16'h0099, 16'h0000, "unmapped");
    endtask : sc_refuse

    // reset lands in the middle of a run; remote fields clear to hold and read back 0x0000
    task sc_midreset;
        wr(KRLTR_CTRL_OFS, 16'h0003);
        repeat (3) @(negedge clk);
        srst = 1'b1;
        pulseCnt = 0;
        repeat (2) @(negedge clk);
        chk("progress in reset", 16'h0000, {15'h0, protocolInProgress});
        chk("enable out in reset", 16'h0001, {15'h0, startupProtocolOn});
        srst = 1'b0;
        rd(KRLTR_DEV_ADDR, KRLTR_LPC_OFS, 16'h0000, "lpc after reset");
        rd(KRLTR_DEV_ADDR, KRLTR_CTRL_OFS, 16'h0002, "ctrl after reset");
        rd(KRLTR_DEV_ADDR, KRLTR_STAT_OFS, 16'h0006, "status after reset");
        chk("autostart again", 16'h0001, 16'(pulseCnt));
    endtask : sc_midreset

    initial begin
        srst = 1'b1;
        {mgmtWrEn, mgmtRdEn, trainFrameLocked, localRxTrained, rxFrameValid} = 5'h00;
        {remotePresetIn, remoteInitIn, failRun} = 3'h0;
        {remoteSwingIn, remotePost2In, remotePostcursorIn, remoteMaincursorIn, remotePrecursorIn} = 10'h000;
        mgmtDevAddr = KRLTR_DEV_ADDR;
        mgmtRegAddr = 16'h0000;
        mgmtWrData = 16'h0000;
        errCount = 0;
        samplesChecked = 0;
        pulseCnt = 0;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        sc_reset();
        sc_done();
        sc_frames();
        sc_ctrl();
        sc_fail();
        sc_refuse();
        sc_midreset();
        close_out();
    end
endmodule : krltr_regs_tb
